// >>> src/page_pkg.sv
package page_pkg;

    // Register offsets within the paged register space
    localparam logic [7:0] CUR_PTR_OFFSET  = 8'hD0;
    localparam logic [7:0] STK_PTR_OFFSET  = 8'hD1;
    localparam logic [7:0] IDX_PTR_OFFSET  = 8'hD3;
    localparam logic [7:0] MOVE_RD_OFFSET  = 8'hD4;
    localparam logic [7:0] MOVE_WR_OFFSET  = 8'hD5;
    localparam logic [7:0] SCRATCH_BASE    = 8'h60;
    localparam logic [7:0] SCRATCH_MASK    = 8'hFC;
    localparam logic [7:0] FLAG_OFFSET     = 8'hF7;

    // Field positions and reset values
    localparam int         MODE_LSB        = 6;
    localparam int         PAGE_W          = 3;
    localparam logic [7:0] PTR_RESET       = 8'h00;
    localparam logic [7:0] FLAG_RESET      = 8'h00;
    localparam logic [7:0] DATA_RESET      = 8'h00;
    localparam logic [7:0] PAGE_FIELD_MASK = 8'h07;
    localparam logic [2:0] PAGE_ZERO       = 3'h0;
    localparam int         SCRATCH_COUNT   = 4;

    // Page-mode encodings
    localparam logic [1:0] MODE_PAGE0      = 2'h0;
    localparam logic [1:0] MODE_STACK_IDX  = 2'h1;
    localparam logic [1:0] MODE_CUR_IDX    = 2'h2;
    localparam logic [1:0] MODE_CUR_STACK  = 2'h3;

    // Kind of SRAM access made by the core
    typedef enum logic [2:0] {
        ACC_NORMAL,
        ACC_INDEXED,
        ACC_STACK,
        ACC_MOVE_PTR,
        ACC_MOVE_READ,
        ACC_MOVE_WRITE
    } access_kind_t;

    // Access request from the core
    typedef struct packed {
        logic         valid;
        access_kind_t kind;
        logic [7:0]   addr;
    } sram_req_t;

    // Physical SRAM address: page above in-page offset
    typedef struct packed {
        logic       valid;
        logic [2:0] page;
        logic [7:0] offset;
    } sram_addr_t;

    // Register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Page pointer set handed to the selector
    typedef struct packed {
        logic [2:0] cur;
        logic [2:0] stk;
        logic [2:0] idx;
        logic [2:0] mvr;
        logic [2:0] mvw;
    } page_ptrs_t;

endpackage

// >>> src/page_flag_reg.sv
`timescale 1ns/1ps
// Flag register holding the page-mode bits, with interrupt save and restore
module page_flag_reg (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Software write
    input  wire logic       flag_wr,
    input  wire logic [7:0] flag_wdata,
    // Interrupt entry and return
    input  wire logic       irq_entry,
    input  wire logic       irq_return,
    input  wire logic [7:0] restore_value,
    // State
    output logic      [7:0] flag,
    output logic      [7:0] saved_flag
);
    import page_pkg::*;

    logic [7:0] next_flag;
    logic [7:0] next_saved_flag;

    // Entry saves then clears; return restores; return outranks software write
    always_comb begin
        next_flag       = flag;
        next_saved_flag = saved_flag;
        if (irq_entry) begin
            next_saved_flag = flag;
            next_flag       = FLAG_RESET;
        end else if (irq_return) begin
            next_flag = restore_value;
        end else if (flag_wr) begin
            next_flag = flag_wdata;
        end
    end

    // Register update
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag       <= FLAG_RESET;
            saved_flag <= FLAG_RESET;
        end else begin
            flag       <= next_flag;
            saved_flag <= next_saved_flag;
        end
    end
endmodule

// >>> src/page_select.sv
`timescale 1ns/1ps
// Combinational page selection for one SRAM access
module page_select (
    // Inputs
    input  wire page_pkg::sram_req_t  req,
    input  wire logic [1:0]           page_mode_bits,
    input  wire page_pkg::page_ptrs_t ptrs,
    // Output
    output page_pkg::sram_addr_t      phys
);
    import page_pkg::*;

    // Indexed page from the page-mode bits
    function automatic logic [2:0] indexed_page(input logic [1:0] m, input page_ptrs_t p);
        case (m)
            MODE_PAGE0:     indexed_page = PAGE_ZERO;
            MODE_STACK_IDX: indexed_page = p.stk;
            MODE_CUR_IDX:   indexed_page = p.idx;
            default:        indexed_page = p.stk;
        endcase
    endfunction

    // Page chosen by access kind
    always_comb begin
        phys.valid  = req.valid;
        phys.offset = req.addr;
        case (req.kind)
            ACC_STACK:      phys.page = ptrs.stk;
            ACC_INDEXED:    phys.page = indexed_page(page_mode_bits, ptrs);
            ACC_MOVE_READ:  phys.page = ptrs.mvr;
            ACC_MOVE_WRITE: phys.page = ptrs.mvw;
            default:        phys.page = page_mode_bits[1] ? ptrs.cur : PAGE_ZERO;
        endcase
    end
endmodule

// >>> src/sram_page_select.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Contract
// - Indexed SRAM page: 00 page 0, 01 stack, 10 index, 11 stack pointer.
// - Normal accesses use current page only in modes 10 and 11.
// - Reset clears page mode to 00, acting like one 256-byte page.
// - Interrupt entry saves flag register then clears it to mode 00.
// - Interrupt return restores saved flags; page pointers are not restored.
// - Indexed register-space accesses are never paged.
// - Four 8-bit scratch registers, read/write, independent of bank.
// - Leading x address means any bank; trailing x means several instances.
// - Current page pointer: three bits, reset zero, selects normal page.
// - Current page pointer never affects indexed or stack accesses.
// - Move pointer byte is fetched and written back like a normal access: current page in modes 10 and 11, page 0 otherwise.
// - Stack page pointer resets to zero; new value used next operation.
// - Stack accesses always use the stack page pointer.
// - Index page pointer: three bits, reset zero, used only in mode 10.
// - Page pointers select one of eight pages by three low bits.
// - Stack pointer wraps 00h to FFh inside one page, no carry.
// - Move data access uses read or write move pointer, ignoring mode.
module sram_page_select (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // Register port
    input  wire logic                 reg_bank,
    input  wire page_pkg::reg_req_t   reg_req,
    output logic      [7:0]           reg_rdata,
    // Core events
    input  wire logic                 irq_entry,
    input  wire logic                 irq_return,
    input  wire logic [7:0]           restore_value,
    // Core SRAM access
    input  wire page_pkg::sram_req_t  core_req,
    input  wire logic                 reg_space,
    // SRAM side
    output page_pkg::sram_addr_t      sram_addr,
    output logic      [1:0]           page_mode_bits,
    output logic      [7:0]           saved_flag
);
    import page_pkg::*;

    logic [7:0]  current_page_pointer;
    logic [7:0]  stack_page_pointer;
    logic [7:0]  index_page_pointer;
    logic [7:0]  move_read_page_pointer;
    logic [7:0]  move_write_page_pointer;
    logic [7:0]  scratch_data_regs [SCRATCH_COUNT];
    logic [7:0]  next_current_page_pointer;
    logic [7:0]  next_stack_page_pointer;
    logic [7:0]  next_index_page_pointer;
    logic [7:0]  next_move_read_page_pointer;
    logic [7:0]  next_move_write_page_pointer;
    logic [7:0]  next_scratch [SCRATCH_COUNT];
    logic [7:0]  next_reg_rdata;
    logic [7:0]  flag;
    logic        flag_wr;
    logic        paged_bank;
    page_ptrs_t  ptrs;
    sram_req_t   gated_req;
    sram_addr_t  next_sram_addr;

    // Scratch registers answer in any bank at 60h..63h
    function automatic logic is_scratch(input logic [7:0] a);
        is_scratch = (a & SCRATCH_MASK) == SCRATCH_BASE;
    endfunction

    // Low page bits of a pointer register
    function automatic logic [2:0] page_of(input logic [7:0] r);
        page_of = r[PAGE_W-1:0];
    endfunction

    // Paging registers live in bank 0; flag register in any bank
    assign paged_bank = !reg_bank;
    assign flag_wr    = reg_req.wr && reg_req.addr == FLAG_OFFSET;

    // Flag register with interrupt save and restore
    page_flag_reg u_flag (
        .ref_clk       (ref_clk),
        .srst          (srst),
        .flag_wr       (flag_wr),
        .flag_wdata    (reg_req.wdata),
        .irq_entry     (irq_entry),
        .irq_return    (irq_return),
        .restore_value (restore_value),
        .flag          (flag),
        .saved_flag    (saved_flag)
    );

    assign page_mode_bits = flag[MODE_LSB+1:MODE_LSB];

    // Pointer writes; pointers are untouched by interrupt return
    always_comb begin
        next_current_page_pointer    = current_page_pointer;
        next_stack_page_pointer      = stack_page_pointer;
        next_index_page_pointer      = index_page_pointer;
        next_move_read_page_pointer  = move_read_page_pointer;
        next_move_write_page_pointer = move_write_page_pointer;
        for (int i = 0; i < SCRATCH_COUNT; i++) begin
            next_scratch[i] = scratch_data_regs[i];
        end
        if (reg_req.wr) begin
            if (is_scratch(reg_req.addr)) begin
                next_scratch[reg_req.addr[1:0]] = reg_req.wdata;
            end else if (paged_bank) begin
                case (reg_req.addr)
                    CUR_PTR_OFFSET: next_current_page_pointer    = reg_req.wdata & PAGE_FIELD_MASK;
                    STK_PTR_OFFSET: next_stack_page_pointer      = reg_req.wdata & PAGE_FIELD_MASK;
                    IDX_PTR_OFFSET: next_index_page_pointer      = reg_req.wdata & PAGE_FIELD_MASK;
                    MOVE_RD_OFFSET: next_move_read_page_pointer  = reg_req.wdata & PAGE_FIELD_MASK;
                    MOVE_WR_OFFSET: next_move_write_page_pointer = reg_req.wdata & PAGE_FIELD_MASK;
                    default: ;
                endcase
            end
        end
    end

    // Read data, valid the cycle after the read strobe
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_req.rd) begin
            if (is_scratch(reg_req.addr)) begin
                next_reg_rdata = scratch_data_regs[reg_req.addr[1:0]];
            end else if (reg_req.addr == FLAG_OFFSET) begin
                next_reg_rdata = flag;
            end else if (paged_bank) begin
                case (reg_req.addr)
                    CUR_PTR_OFFSET: next_reg_rdata = current_page_pointer;
                    STK_PTR_OFFSET: next_reg_rdata = stack_page_pointer;
                    IDX_PTR_OFFSET: next_reg_rdata = index_page_pointer;
                    MOVE_RD_OFFSET: next_reg_rdata = move_read_page_pointer;
                    MOVE_WR_OFFSET: next_reg_rdata = move_write_page_pointer;
                    default:       next_reg_rdata = 8'h00;
                endcase
            end
        end
    end

    // Register state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            current_page_pointer    <= PTR_RESET;
            stack_page_pointer      <= PTR_RESET;
            index_page_pointer      <= PTR_RESET;
            move_read_page_pointer  <= PTR_RESET;
            move_write_page_pointer <= PTR_RESET;
            for (int i = 0; i < SCRATCH_COUNT; i++) begin
                scratch_data_regs[i] <= DATA_RESET;
            end
            reg_rdata <= DATA_RESET;
        end else begin
            current_page_pointer    <= next_current_page_pointer;
            stack_page_pointer      <= next_stack_page_pointer;
            index_page_pointer      <= next_index_page_pointer;
            move_read_page_pointer  <= next_move_read_page_pointer;
            move_write_page_pointer <= next_move_write_page_pointer;
            for (int i = 0; i < SCRATCH_COUNT; i++) begin
                scratch_data_regs[i] <= next_scratch[i];
            end
            reg_rdata <= next_reg_rdata;
        end
    end

    // Three low bits choose one of eight pages
    always_comb begin
        ptrs.cur = page_of(current_page_pointer);
        ptrs.stk = page_of(stack_page_pointer);
        ptrs.idx = page_of(index_page_pointer);
        ptrs.mvr = page_of(move_read_page_pointer);
        ptrs.mvw = page_of(move_write_page_pointer);
    end

    // Register-space accesses never reach the paged SRAM
    always_comb begin
        gated_req       = core_req;
        gated_req.valid = core_req.valid && !reg_space;
    end

    // Page selection; stack offset is the 8-bit pointer, so it wraps in page
    page_select u_select (
        .req            (gated_req),
        .page_mode_bits (page_mode_bits),
        .ptrs           (ptrs),
        .phys           (next_sram_addr)
    );

    // Registered SRAM address
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sram_addr <= '0;
        end else begin
            sram_addr <= next_sram_addr;
        end
    end
endmodule

// >>> bench/page_sva.sv
`timescale 1ns/1ps
// Port-level checker for the page selector
module page_sva (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 srst,
    // Register port and core events
    input wire logic                 reg_bank,
    input wire page_pkg::reg_req_t   reg_req,
    input wire logic [7:0]           reg_rdata,
    input wire logic                 irq_entry,
    input wire logic                 irq_return,
    input wire logic [7:0]           restore_value,
    // SRAM access
    input wire page_pkg::sram_req_t  core_req,
    input wire logic                 reg_space,
    input wire page_pkg::sram_addr_t sram_addr,
    input wire logic [1:0]           page_mode_bits,
    input wire logic [7:0]           saved_flag
);
    import page_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Helper views of request fields
    logic       take;
    logic       rd_s;
    logic [1:0] rv_mode;
    assign take    = core_req.valid && !reg_space;
    assign rd_s    = reg_req.rd;
    assign rv_mode = restore_value[7:6];

    a_reset_mode: assert property ($fell(srst) |-> page_mode_bits == MODE_PAGE0 && sram_addr == '0)
        else $error("mode or address not clear after reset");
    a_offset_pass: assert property (take |=> sram_addr.valid && sram_addr.offset == $past(core_req.addr))
        else $error("in-page offset not passed through");
    a_reg_space: assert property (core_req.valid && reg_space |=> !sram_addr.valid)
        else $error("register space access reached sram");
    a_normal_page0: assert property (take && core_req.kind inside {ACC_NORMAL, ACC_MOVE_PTR}
        && !page_mode_bits[1] |=> sram_addr.page == PAGE_ZERO)
        else $error("normal access left page zero");
    a_index_page0: assert property (take && core_req.kind == ACC_INDEXED && page_mode_bits == MODE_PAGE0
        |=> sram_addr.page == PAGE_ZERO)
        else $error("indexed access left page zero");
    a_entry_clear: assert property (irq_entry |=> page_mode_bits == MODE_PAGE0
        && saved_flag[7:6] == $past(page_mode_bits))
        else $error("entry did not save and clear mode");
    a_return_mode: assert property (irq_return && !irq_entry |=> page_mode_bits == $past(rv_mode))
        else $error("return did not restore mode");
    a_rdata_quiet: assert property (!$past(rd_s) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    // Main scenarios
    cover property (irq_entry ##1 irq_return);
    cover property (take && core_req.kind == ACC_MOVE_WRITE);
    cover property (rd_s ##1 reg_rdata != 8'h00);
endmodule
bind sram_page_select page_sva i_page_sva (.ref_clk, .srst, .reg_bank, .reg_req, .reg_rdata, .irq_entry,
    .irq_return, .restore_value, .core_req, .reg_space, .sram_addr, .page_mode_bits, .saved_flag);

// >>> bench/paged_sram_model.sv
`timescale 1ns/1ps
// Paged SRAM stand-in: keeps the last physical address it was given
module paged_sram_model (
    // Clock
    input  wire logic                 ref_clk,
    // Access from the selector
    input  wire page_pkg::sram_addr_t sram_addr,
    // Observation
    output logic      [10:0]          last_phys
);
    import page_pkg::*;
    // Eight pages of 256 bytes, page number on top
    always @(posedge ref_clk) begin
        if (sram_addr.valid === 1'b1) begin
            last_phys <= {sram_addr.page, sram_addr.offset};
        end
    end
endmodule

// >>> bench/sram_page_select_tb.sv
`timescale 1ns/1ps
// Self-checking bench with a reference model of the page selector
module sram_page_select_tb;
    import page_pkg::*;
    // Design inputs
    logic        ref_clk       = 1'b0;
    logic        srst          = 1'b1;
    logic        reg_bank      = 1'b0;
    reg_req_t    reg_req       = '0;
    logic        irq_entry     = 1'b0;
    logic        irq_return    = 1'b0;
    logic [7:0]  restore_value = 8'h00;
    sram_req_t   core_req      = '0;
    logic        reg_space     = 1'b0;
    // Design outputs
    logic [7:0]  reg_rdata;
    sram_addr_t  sram_addr;
    logic [1:0]  page_mode_bits;
    logic [7:0]  saved_flag;
    logic [10:0] last_phys;
    // Model state and expectations of the previous step
    int cur, stk, idx, mvr, mvw, flag, saved, last, seed;
    int e_rd, e_v, e_ph, e_fl, e_sv, err_total, checks_done;
    int scr[4];
    int tbl[10] = '{8'hD0, 8'hD1, 8'hD3, 8'hD4, 8'hD5, 8'h60, 8'h63, 8'hF7, 8'h80, 8'hD2};

    always #5 ref_clk = ~ref_clk;

    sram_page_select i_sram_page_select (.ref_clk, .srst, .reg_bank, .reg_req, .reg_rdata, .irq_entry,
        .irq_return, .restore_value, .core_req, .reg_space, .sram_addr, .page_mode_bits, .saved_flag);
    paged_sram_model i_paged_sram_model (.ref_clk, .sram_addr, .last_phys);

    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Register read as seen by software
    function automatic int rdv(int a, int b);
        if (a >= 8'h60 && a <= 8'h63) return scr[a - 8'h60];
        if (a == 8'hF7) return flag;
        if (b != 0) return 0;
        case (a)
            8'hD0: return cur;
            8'hD1: return stk;
            8'hD3: return idx;
            8'hD4: return mvr;
            8'hD5: return mvw;
            default: return 0;
        endcase
    endfunction

    // Page chosen for one access kind
    function automatic int pg(access_kind_t k);
        int m;
        m = flag >> 6;
        case (k)
            ACC_STACK: return stk;
            ACC_INDEXED: return (m == 0) ? 0 : (m == 2) ? idx : stk;
            ACC_MOVE_READ: return mvr;
            ACC_MOVE_WRITE: return mvw;
            default: return (m >= 2) ? cur : 0;
        endcase
    endfunction

    // One clock of stimulus; checks what the previous step produced
    task automatic step(reg_req_t r, logic b, logic ie, logic ir, logic [7:0] rv, sram_req_t c, logic rs);
        int n_rd, n_v, n_ph;
        n_rd = r.rd ? rdv(r.addr, b) : 0;
        n_v = c.valid && !rs;
        n_ph = pg(c.kind) * 256 + c.addr;
        if (n_v) last = n_ph;
        if (r.wr && r.addr >= 8'h60 && r.addr <= 8'h63) scr[r.addr - 8'h60] = r.wdata;
        else if (r.wr && !b) begin
            case (r.addr)
                8'hD0: cur = r.wdata & 7;
                8'hD1: stk = r.wdata & 7;
                8'hD3: idx = r.wdata & 7;
                8'hD4: mvr = r.wdata & 7;
                8'hD5: mvw = r.wdata & 7;
                default: ;
            endcase
        end
        if (ie) begin
            saved = flag;
            flag = 0;
        end
        else if (ir) flag = rv;
        else if (r.wr && r.addr == 8'hF7) flag = r.wdata;
        reg_req <= r;
        reg_bank <= b;
        irq_entry <= ie;
        irq_return <= ir;
        restore_value <= rv;
        core_req <= c;
        reg_space <= rs;
        @(posedge ref_clk);
        check("read data", reg_rdata, e_rd);
        check("sram valid", sram_addr.valid, e_v);
        if (e_v) check("sram address", {sram_addr.page, sram_addr.offset}, e_ph);
        check("page mode", page_mode_bits, e_fl >> 6);
        check("saved flag", saved_flag, e_sv);
        {e_rd, e_v, e_ph, e_fl, e_sv} = {n_rd, n_v, n_ph, flag, saved};
    endtask

    task automatic wr(int a, int d, int b = 0);
        step('{1'b1, 1'b0, 8'(a), 8'(d)}, 1'(b), 0, 0, 8'h00, '0, 0);
    endtask

    task automatic rd(int a, int b = 0);
        step('{1'b0, 1'b1, 8'(a), 8'h00}, 1'(b), 0, 0, 8'h00, '0, 0);
    endtask

    task automatic acc(access_kind_t k, int a, int rs = 0);
        step('0, 0, 0, 0, 8'h00, '{1'b1, k, 8'(a)}, 1'(rs));
    endtask

    task automatic ev(int ie, int ir, int rv);
        step('0, 0, 1'(ie), 1'(ir), 8'(rv), '0, 0);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        int o, a, d;
        seed = 32'h0A0E;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        // Reset values, unmapped place and bank reach
        foreach (tbl[i]) rd(tbl[i]);
        wr(8'hD0, 5, 1);
        wr(8'h61, 8'hA5, 1);
        rd(8'hD0);
        rd(8'h61);
        $display("test reset done");
        // Every mode against every access kind
        wr(8'hD0, 1);
        wr(8'hD1, 2);
        wr(8'hD3, 3);
        wr(8'hD4, 4);
        wr(8'hD5, 5);
        for (int m = 0; m < 4; m++) begin
            wr(8'hF7, m << 6);
            for (int k = 0; k < 6; k++) acc(access_kind_t'(k), 8'hF0 + k);
            acc(ACC_INDEXED, 8'h22, 1);
        end
        wr(8'hD1, 6);
        acc(ACC_STACK, 8'hFF);
        $display("test page modes done");
        // Interrupt entry, handler changes and return
        wr(8'hF7, 8'hC0);
        ev(1, 0, 0);
        acc(ACC_NORMAL, 8'h10);
        acc(ACC_INDEXED, 8'h11);
        wr(8'hF7, 8'h40);
        acc(ACC_INDEXED, 8'h12);
        wr(8'hD1, 7);
        wr(8'hD1, 6);
        ev(1, 1, 8'h80);
        ev(0, 1, 8'hC0);
        acc(ACC_NORMAL, 8'h13);
        rd(8'hF7);
        $display("test interrupt done");
        // Random traffic on every input
        repeat (400) begin
            o = $unsigned($random(seed)) % 8;
            a = tbl[$unsigned($random(seed)) % 10];
            d = $random(seed) & 8'hFF;
            if (a >= 8'hD0 && a <= 8'hD5) d = d & 7;
            step('{o < 3, o == 3, 8'(a), 8'(d)}, 1'($random(seed)), o == 5, o == 6, 8'($random(seed)),
                 '{1'($random(seed)), access_kind_t'($unsigned($random(seed)) % 6), 8'($random(seed))},
                 $unsigned($random(seed)) % 8 == 0);
        end
        ev(0, 0, 0);
        ev(0, 0, 0);
        check("sram model", last_phys, last);
        $display("test random done");
        tally_and_finish();
    end
endmodule
